// *** logic/msp_params.svh ***
// timing counts, sync bit positions and reset values for the modem serial ports
// assumes a single 125 MHz ref_clk and a fixed line rate
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH

`define MSP_CLK_PERIOD_NS  8
`define MSP_CLK_HZ         125000000
`define MSP_BAUD           115200
// bit time rounded down to whole clocks
`define MSP_CLKS_PER_BIT   (`MSP_CLK_HZ / `MSP_BAUD)
`define MSP_DATA_BITS      8

// positions inside the input synchroniser vector
`define MSP_SY_RXM         0
`define MSP_SY_AUXIN       1
`define MSP_SY_RTS         2
`define MSP_SY_DTR         3
`define MSP_SY_DCD         4
`define MSP_SY_DSR         5
`define MSP_SY_RI          6
`define MSP_SY_W           7
// idle lines and unconnected pulled-up inputs read high
`define MSP_SY_RST         7'h7F

// positions inside the four reconfigurable modem lines
`define MSP_G_DCD          0
`define MSP_G_DTR          1
`define MSP_G_DSR          2
`define MSP_G_RI           3
`endif

// *** logic/msp_pkg.sv ***
// state types shared by the serial port modules
// assumes nothing beyond the params header
package msp_pkg;
  typedef enum logic [1:0] {
    MSP_TX_IDLE  = 2'b00,
    MSP_TX_START = 2'b01,
    MSP_TX_DATA  = 2'b10,
    MSP_TX_STOP  = 2'b11
  } msp_tx_state_t;

  typedef enum logic [1:0] {
    MSP_RX_IDLE  = 2'b00,
    MSP_RX_START = 2'b01,
    MSP_RX_DATA  = 2'b10,
    MSP_RX_STOP  = 2'b11
  } msp_rx_state_t;
endpackage

// *** logic/msp_uart_tx.sv ***
// 8N1 character transmitter
// assumes startValid is only raised while ready is high
`include "msp_params.svh"
module msp_uart_tx #(
  parameter int CLKS_PER_BIT = `MSP_CLKS_PER_BIT
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       startValid,
  input  wire logic [7:0] startData,
  output logic            ready,
  output logic            txLine
);
  localparam int CW = $clog2(CLKS_PER_BIT);
  localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);

  msp_pkg::msp_tx_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [2:0]    bit_q, bit_d;
  logic [7:0]    shr_q, shr_d;
  logic          line_q, line_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CW'(1);
    bit_d   = bit_q;
    shr_d   = shr_q;
    line_d  = line_q;
    unique case (state_q)
      msp_pkg::MSP_TX_IDLE: begin
        cnt_d  = '0;
        line_d = 1'b1;
        if (startValid) begin
          shr_d   = startData;
          line_d  = 1'b0;
          state_d = msp_pkg::MSP_TX_START;
        end
      end
      msp_pkg::MSP_TX_START: begin
        if (cnt_q == LAST) begin
          cnt_d   = '0;
          bit_d   = 3'h0;
          line_d  = shr_q[0];
          state_d = msp_pkg::MSP_TX_DATA;
        end
      end
      msp_pkg::MSP_TX_DATA: begin
        if (cnt_q == LAST) begin
          cnt_d = '0;
          shr_d = {1'b1, shr_q[7:1]};
          bit_d = bit_q + 3'h1;
          line_d = shr_q[1];
          if (bit_q == 3'h7) begin
            line_d  = 1'b1;
            state_d = msp_pkg::MSP_TX_STOP;
          end
        end
      end
      msp_pkg::MSP_TX_STOP: begin
        if (cnt_q == LAST) begin
          cnt_d   = '0;
          state_d = msp_pkg::MSP_TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= msp_pkg::MSP_TX_IDLE;
      cnt_q   <= '0;
      bit_q   <= 3'h0;
      shr_q   <= 8'h00;
      line_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      shr_q   <= shr_d;
      line_q  <= line_d;
    end
  end

  assign ready  = (state_q == msp_pkg::MSP_TX_IDLE);
  assign txLine = line_q;
endmodule // msp_uart_tx

// *** logic/msp_uart_rx.sv ***
// 8N1 character receiver, samples mid-bit
// assumes rxLine is already synchronised to ref_clk
`include "msp_params.svh"
module msp_uart_rx #(
  parameter int CLKS_PER_BIT = `MSP_CLKS_PER_BIT
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       rxLine,
  output logic            byteValid,
  output logic [7:0]      byteData,
  output logic            frameErr
);
  localparam int CW = $clog2(CLKS_PER_BIT);
  localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);

  msp_pkg::msp_rx_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [2:0]    bit_q, bit_d;
  logic [7:0]    shr_q, shr_d;
  logic          vld_q, vld_d;
  logic          ferr_q, ferr_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CW'(1);
    bit_d   = bit_q;
    shr_d   = shr_q;
    vld_d   = 1'b0;
    ferr_d  = 1'b0;
    unique case (state_q)
      msp_pkg::MSP_RX_IDLE: begin
        cnt_d = '0;
        if (!rxLine) state_d = msp_pkg::MSP_RX_START;
      end
      msp_pkg::MSP_RX_START: begin
        // a glitch shorter than half a bit is dropped
        if (cnt_q == HALF) begin
          cnt_d   = '0;
          bit_d   = 3'h0;
          state_d = rxLine ? msp_pkg::MSP_RX_IDLE : msp_pkg::MSP_RX_DATA;
        end
      end
      msp_pkg::MSP_RX_DATA: begin
        if (cnt_q == LAST) begin
          cnt_d = '0;
          shr_d = {rxLine, shr_q[7:1]};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) state_d = msp_pkg::MSP_RX_STOP;
        end
      end
      msp_pkg::MSP_RX_STOP: begin
        if (cnt_q == LAST) begin
          cnt_d   = '0;
          vld_d   = rxLine;
          ferr_d  = !rxLine;
          state_d = msp_pkg::MSP_RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= msp_pkg::MSP_RX_IDLE;
      cnt_q   <= '0;
      bit_q   <= 3'h0;
      shr_q   <= 8'h00;
      vld_q   <= 1'b0;
      ferr_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      shr_q   <= shr_d;
      vld_q   <= vld_d;
      ferr_q  <= ferr_d;
    end
  end

  assign byteValid = vld_q;
  assign byteData  = shr_q;
  assign frameErr  = ferr_q;
endmodule // msp_uart_rx

// *** logic/msp_serial_ports.sv ***
// main modem UART with modem control lines, and auxiliary console UART sharing pins with the SPI master
// assumes one 125 MHz clock; pad inputs are asynchronous; pull-up and level translation are outside
//
// Contract
// - modem lines use active-low logic polarity
// - transmit data leaves on device transmit pin
// - receive data sampled from device receive pin
// - pin names follow the terminal side convention
// - set-ready output shows module is ready
// - ring output shows incoming call condition
// - terminal-ready low blocks low-power entry
// - unconnected terminal-ready reads high
// - four modem lines reconfigurable as GPIO
// - minimal link needs only data lines
// - auxiliary port has data lines only
// - auxiliary UART and SPI never both active
// - auxiliary UART is the debug console
`include "msp_params.svh"
module msp_serial_ports #(
  parameter int CLKS_PER_BIT = `MSP_CLKS_PER_BIT
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // main port data pins
  input  wire logic       mainRxPin,
  output logic            mainTxPin,
  // main port modem control pins, active low, with active-high output enables
  input  wire logic       requestToSendPinN,
  output logic            clearToSendPinN,
  input  wire logic       carrierDetectPinIn,
  output logic            carrierDetectOutN,
  output logic            carrierDetectOe,
  input  wire logic       termReadyPinIn,
  output logic            termReadyPinOut,
  output logic            termReadyPinOe,
  input  wire logic       setReadyPinIn,
  output logic            setReadyOutN,
  output logic            setReadyOe,
  input  wire logic       ringPinIn,
  output logic            ringIndicatorOutN,
  output logic            ringIndicatorOe,
  // auxiliary pins shared with the SPI master
  input  wire logic       auxRxMisoPin,
  output logic            auxTxMosiPin,
  // modem-side control and status
  input  wire logic       carrierPresent,
  input  wire logic       moduleReady,
  input  wire logic       incomingCall,
  input  wire logic       flowCtrlEn,
  input  wire logic [3:0] gpioModeEn,
  input  wire logic [3:0] gpioOutVal,
  input  wire logic [3:0] gpioDirOut,
  output logic [3:0]      gpioInVal,
  output logic            lowPowerAllowed,
  // main port character interface
  input  wire logic       mainTxValid,
  input  wire logic [7:0] mainTxData,
  output logic            mainTxReady,
  output logic            mainRxValid,
  output logic [7:0]      mainRxData,
  input  wire logic       mainRxTaken,
  output logic            mainRxOverrun,
  output logic            mainRxFrameErr,
  // debug console character interface
  input  wire logic       auxTxValid,
  input  wire logic [7:0] auxTxData,
  output logic            auxTxReady,
  output logic            auxRxValid,
  output logic [7:0]      auxRxData,
  // SPI master data, only while spiSelect is high
  input  wire logic       spiSelect,
  input  wire logic       spiMosi,
  output logic            spiMiso
);
  // ==========================================================================
  // input synchronisers
  logic [`MSP_SY_W-1:0] padIn;
  logic [`MSP_SY_W-1:0] syA_q, syB_q;

  assign padIn[`MSP_SY_RXM]   = mainRxPin;
  assign padIn[`MSP_SY_AUXIN] = auxRxMisoPin;
  assign padIn[`MSP_SY_RTS]   = requestToSendPinN;
  assign padIn[`MSP_SY_DTR]   = termReadyPinIn;
  assign padIn[`MSP_SY_DCD]   = carrierDetectPinIn;
  assign padIn[`MSP_SY_DSR]   = setReadyPinIn;
  assign padIn[`MSP_SY_RI]    = ringPinIn;

  // reset to all ones so idle data lines and a floating terminal-ready read high
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      syA_q <= `MSP_SY_RST;
      syB_q <= `MSP_SY_RST;
    end else begin
      syA_q <= padIn;
      syB_q <= syA_q;
    end
  end

  // ==========================================================================
  // main port datapath
  logic       mTxStart;
  logic       mTxIdle;
  logic       mTxLine;
  logic       mRxVld;
  logic [7:0] mRxByte;
  logic       mRxFerr;
  logic       rtsAsserted;

  // request-to-send is low-true on the pin
  assign rtsAsserted = !syB_q[`MSP_SY_RTS];
  // the host may only pause characters not yet started
  assign mTxStart    = mainTxValid && mTxIdle && (!flowCtrlEn || rtsAsserted);

  msp_uart_tx #(
    .CLKS_PER_BIT (CLKS_PER_BIT)
  ) u_main_tx (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .startValid (mTxStart),
    .startData  (mainTxData),
    .ready      (mTxIdle),
    .txLine     (mTxLine)
  );

  msp_uart_rx #(
    .CLKS_PER_BIT (CLKS_PER_BIT)
  ) u_main_rx (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .rxLine    (syB_q[`MSP_SY_RXM]),
    .byteValid (mRxVld),
    .byteData  (mRxByte),
    .frameErr  (mRxFerr)
  );

  // ==========================================================================
  // auxiliary console datapath, no modem lines and no flow control
  logic       aTxStart;
  logic       aTxIdle;
  logic       aTxLine;
  logic       aRxVld;
  logic [7:0] aRxByte;
  logic       aRxLine;

  // while SPI owns the pins the console receiver sees an idle line
  assign aRxLine  = spiSelect | syB_q[`MSP_SY_AUXIN];
  assign aTxStart = auxTxValid && aTxIdle && !spiSelect;

  msp_uart_tx #(
    .CLKS_PER_BIT (CLKS_PER_BIT)
  ) u_aux_tx (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .startValid (aTxStart),
    .startData  (auxTxData),
    .ready      (aTxIdle),
    .txLine     (aTxLine)
  );

  msp_uart_rx #(
    .CLKS_PER_BIT (CLKS_PER_BIT)
  ) u_aux_rx (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .rxLine    (aRxLine),
    .byteValid (aRxVld),
    .byteData  (aRxByte),
    .frameErr  ()
  );

  // ==========================================================================
  // receive holding register and status
  logic       hold_q, hold_d;
  logic [7:0] hByte_q, hByte_d;
  logic       ovr_q, ovr_d;
  logic       ferr_q, ferr_d;
  logic       cts_q, cts_d;

  always_comb begin
    hold_d  = hold_q;
    hByte_d = hByte_q;
    ovr_d   = ovr_q;
    ferr_d  = ferr_q;
    if (mainRxTaken) begin
      hold_d = 1'b0;
      ovr_d  = 1'b0;
      ferr_d = 1'b0;
    end
    // a new character or error wins over the take in the same cycle
    if (mRxVld) begin
      if (hold_q && !mainRxTaken) begin
        ovr_d = 1'b1;
      end else begin
        hold_d  = 1'b1;
        hByte_d = mRxByte;
      end
    end
    if (mRxFerr) ferr_d = 1'b1;
    // low-true pin: high means stop sending, which is exactly while a character waits
    cts_d = hold_d;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hold_q  <= 1'b0;
      hByte_q <= 8'h00;
      ovr_q   <= 1'b0;
      ferr_q  <= 1'b0;
      cts_q   <= 1'b0;
    end else begin
      hold_q  <= hold_d;
      hByte_q <= hByte_d;
      ovr_q   <= ovr_d;
      ferr_q  <= ferr_d;
      cts_q   <= cts_d;
    end
  end

  // ==========================================================================
  // pin and user-side output registers
  logic       mTx_q, mTx_d;
  logic       auxPin_q, auxPin_d;
  logic       miso_q, miso_d;
  logic [3:0] gOut_q, gOut_d;
  logic [3:0] gOe_q, gOe_d;
  logic [3:0] gIn_q, gIn_d;
  logic       lpa_q, lpa_d;
  logic       mTxRdy_q, mTxRdy_d;
  logic       aTxRdy_q, aTxRdy_d;
  logic       aVld_q, aVld_d;
  logic [7:0] aByte_q, aByte_d;
  logic [3:0] uartLvl;
  logic       dtrLow;

  // modem-side levels for the modem role of each line, low-true on the pin
  assign uartLvl[`MSP_G_DCD] = !carrierPresent;
  assign uartLvl[`MSP_G_DTR] = 1'b1;
  assign uartLvl[`MSP_G_DSR] = !moduleReady;
  assign uartLvl[`MSP_G_RI]  = !incomingCall;
  assign dtrLow = !syB_q[`MSP_SY_DTR];

  always_comb begin
    mTx_d    = mTxLine;
    auxPin_d = spiSelect ? spiMosi : aTxLine;
    miso_d   = spiSelect & syB_q[`MSP_SY_AUXIN];
    for (int i = 0; i < 4; i++) begin
      gOut_d[i] = gpioModeEn[i] ? gpioOutVal[i] : uartLvl[i];
      gOe_d[i]  = gpioModeEn[i] ? gpioDirOut[i] : (i != `MSP_G_DTR);
    end
    gIn_d[`MSP_G_DCD] = syB_q[`MSP_SY_DCD];
    gIn_d[`MSP_G_DTR] = syB_q[`MSP_SY_DTR];
    gIn_d[`MSP_G_DSR] = syB_q[`MSP_SY_DSR];
    gIn_d[`MSP_G_RI]  = syB_q[`MSP_SY_RI];
    // a line given over to GPIO no longer holds the module awake
    lpa_d    = gpioModeEn[`MSP_G_DTR] || !dtrLow;
    // high in the cycle after a take too, so a held request always sees it once
    mTxRdy_d = mTxIdle && (!flowCtrlEn || rtsAsserted);
    aTxRdy_d = aTxIdle && !spiSelect;
    aVld_d   = aRxVld && !spiSelect;
    aByte_d  = aRxVld ? aRxByte : aByte_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mTx_q    <= 1'b1;
      auxPin_q <= 1'b1;
      miso_q   <= 1'b0;
      gOut_q   <= 4'hF;
      gOe_q    <= 4'h0;
      gIn_q    <= 4'hF;
      lpa_q    <= 1'b1;
      mTxRdy_q <= 1'b0;
      aTxRdy_q <= 1'b0;
      aVld_q   <= 1'b0;
      aByte_q  <= 8'h00;
    end else begin
      mTx_q    <= mTx_d;
      auxPin_q <= auxPin_d;
      miso_q   <= miso_d;
      gOut_q   <= gOut_d;
      gOe_q    <= gOe_d;
      gIn_q    <= gIn_d;
      lpa_q    <= lpa_d;
      mTxRdy_q <= mTxRdy_d;
      aTxRdy_q <= aTxRdy_d;
      aVld_q   <= aVld_d;
      aByte_q  <= aByte_d;
    end
  end

  // ==========================================================================
  // output wiring, every output is a flop
  assign mainTxPin         = mTx_q;
  assign clearToSendPinN   = cts_q;
  assign carrierDetectOutN = gOut_q[`MSP_G_DCD];
  assign carrierDetectOe   = gOe_q[`MSP_G_DCD];
  assign termReadyPinOut   = gOut_q[`MSP_G_DTR];
  assign termReadyPinOe    = gOe_q[`MSP_G_DTR];
  assign setReadyOutN      = gOut_q[`MSP_G_DSR];
  assign setReadyOe        = gOe_q[`MSP_G_DSR];
  assign ringIndicatorOutN = gOut_q[`MSP_G_RI];
  assign ringIndicatorOe   = gOe_q[`MSP_G_RI];
  assign auxTxMosiPin      = auxPin_q;
  assign gpioInVal         = gIn_q;
  assign lowPowerAllowed   = lpa_q;
  // tx ready is one cycle stale; a start is only taken when the sender is idle
  assign mainTxReady       = mTxRdy_q;
  assign mainRxValid       = hold_q;
  assign mainRxData        = hByte_q;
  assign mainRxOverrun     = ovr_q;
  assign mainRxFrameErr    = ferr_q;
  assign auxTxReady        = aTxRdy_q;
  assign auxRxValid        = aVld_q;
  assign auxRxData         = aByte_q;
  assign spiMiso           = miso_q;
endmodule // msp_serial_ports

// *** verif/msp_serial_ports_asserts.sv ***
// checker for the modem serial ports, seeing only the top ports
// assumes one clock and the synchronous active-low reset
// ====================
// port assertions
module msp_serial_ports_asserts (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       requestToSendPinN,
  input wire logic       termReadyPinIn,
  input wire logic       carrierPresent,
  input wire logic       moduleReady,
  input wire logic       incomingCall,
  input wire logic       flowCtrlEn,
  input wire logic [3:0] gpioModeEn,
  input wire logic       spiSelect,
  input wire logic       spiMosi,
  input wire logic       mainTxPin,
  input wire logic       clearToSendPinN,
  input wire logic       carrierDetectOutN,
  input wire logic       setReadyOutN,
  input wire logic       setReadyOe,
  input wire logic       ringIndicatorOutN,
  input wire logic       lowPowerAllowed,
  input wire logic       mainTxReady,
  input wire logic       mainRxValid,
  input wire logic       auxTxMosiPin,
  input wire logic       spiMiso
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // two sync stages plus the output flop, so five cycles leaves margin
  sequence dtrLow;
    (!termReadyPinIn && !gpioModeEn[1])[*5];
  endsequence
  sequence rtsOff;
    (flowCtrlEn && requestToSendPinN)[*4];
  endsequence
  chk_reset_state: assert property (disable iff (1'h0) !rstn |=> mainTxPin && !clearToSendPinN && !setReadyOe)
    else $error("lines not at rest after reset");
  chk_dcd_line: assert property ($past(rstn) && !$past(gpioModeEn[0]) |-> carrierDetectOutN == !$past(carrierPresent))
    else $error("carrier detect polarity");
  chk_dsr_line: assert property ($past(rstn) && !$past(gpioModeEn[2]) |-> setReadyOe && setReadyOutN == !$past(moduleReady))
    else $error("set ready wrong");
  chk_ring_line: assert property ($past(rstn) && !$past(gpioModeEn[3]) |-> ringIndicatorOutN == !$past(incomingCall))
    else $error("ring wrong");
  chk_cts_held: assert property (clearToSendPinN == mainRxValid)
    else $error("clear to send not tracking held char");
  chk_dtr_block: assert property (dtrLow |-> !lowPowerAllowed)
    else $error("sleep allowed with terminal ready low");
  chk_rts_pause: assert property (rtsOff |-> !mainTxReady)
    else $error("transmit ready while paused");
  chk_spi_miso: assert property ($past(rstn) && !$past(spiSelect) |-> !spiMiso)
    else $error("miso active without select");
  chk_mosi_route: assert property ($past(rstn) && $past(spiSelect) |-> auxTxMosiPin == $past(spiMosi))
    else $error("shared pin not routed to spi");
endmodule // msp_serial_ports_asserts

// *** verif/msp_host_model.sv ***
// host uart: drives device receive and request-to-send, decodes device transmit
// assumes 8N1 at BIT clocks per bit of ref_clk
// ====================
// host model
module msp_host_model #(
  parameter int BIT = 8
) (
  input  wire logic ref_clk,
  input  wire logic mainTxPin,
  output logic      mainRxPin,
  output logic      requestToSendPinN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       holdOff = 1'h0;
  logic [7:0] rxByte;
  int         rxCount = 0;
  assign requestToSendPinN = holdOff;
  initial mainRxPin = 1'h1;
  task automatic sendByte(input logic [7:0] b, input logic stopBit);
    @(posedge ref_clk);
    mainRxPin <= 1'h0;
    repeat (BIT) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      mainRxPin <= b[i];
      repeat (BIT) @(posedge ref_clk);
    end
    mainRxPin <= stopBit;
    repeat (BIT) @(posedge ref_clk);
    mainRxPin <= 1'h1;
    repeat (2 * BIT) @(posedge ref_clk);
  endtask
  // mid-bit sampling, lsb first
  always begin
    @(negedge mainTxPin);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      rxByte[i] = mainTxPin;
    end
    repeat (BIT) @(posedge ref_clk);
    rxCount++;
  end
endmodule // msp_host_model

// *** verif/testbench.sv ***
// self-checking bench for the modem serial ports with a host model
// assumes the design built with a short bit time
// ====================
// bench
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = 8;
  logic       ref_clk, rstn, carrierPresent, moduleReady, incomingCall, flowCtrlEn;
  logic       mainTxValid, mainRxTaken, auxTxValid, spiSelect, spiMosi, mainTxPin, clearToSendPinN;
  logic       carrierDetectOutN, carrierDetectOe, termReadyPinOut, termReadyPinOe, setReadyOutN, setReadyOe;
  logic       ringIndicatorOutN, ringIndicatorOe, auxTxMosiPin, lowPowerAllowed, mainTxReady, mainRxValid;
  logic       mainRxOverrun, mainRxFrameErr, auxTxReady, auxRxValid, spiMiso;
  logic [7:0] mainTxData, auxTxData, mainRxData, auxRxData;
  logic [3:0] gpioModeEn, gpioOutVal, gpioDirOut, gpioInVal, ext;
  wire        mainRxPin, requestToSendPinN;
  int         mismatches = 0;
  int         total_checks = 0;
  // undriven pins sit at the pull-up level
  wire carrierDetectPinIn = carrierDetectOe ? carrierDetectOutN : ext[0];
  wire termReadyPinIn = termReadyPinOe ? termReadyPinOut : ext[1];
  wire setReadyPinIn = setReadyOe ? setReadyOutN : ext[2];
  wire ringPinIn = ringIndicatorOe ? ringIndicatorOutN : ext[3];
  // console looped back so both directions run
  wire auxRxMisoPin = auxTxMosiPin;
  msp_serial_ports #(.CLKS_PER_BIT(BIT)) dut (.*);
  msp_host_model #(.BIT(BIT)) host (
    .ref_clk(ref_clk),
    .mainTxPin(mainTxPin),
    .mainRxPin(mainRxPin),
    .requestToSendPinN(requestToSendPinN)
  );
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chkb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic take;
    @(posedge ref_clk);
    mainRxTaken <= 1'h1;
    @(posedge ref_clk);
    mainRxTaken <= 1'h0;
    tick(1);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_modem;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {carrierPresent, moduleReady, incomingCall} <= 3'(i);
      tick(2);
      chkb(carrierDetectOutN, !i[2]);
      chkb(setReadyOutN, !i[1]);
      chkb(ringIndicatorOutN, !i[0]);
    end
  endtask
  task automatic t_dtr;
    @(posedge ref_clk);
    ext[1] <= 1'h0;
    tick(5);
    chkb(lowPowerAllowed, 1'h0);
    @(posedge ref_clk);
    ext[1] <= 1'h1;
    tick(5);
    chkb(lowPowerAllowed, 1'h1);
  endtask
  task automatic t_gpio;
    @(posedge ref_clk);
    {gpioModeEn, gpioDirOut, gpioOutVal, ext} <= 16'hF518;
    tick(6);
    chk({4'h0, gpioInVal}, 8'h09);
    chkb(lowPowerAllowed, 1'h1);
    chk({3'h0, termReadyPinOut, ringIndicatorOe, setReadyOe, termReadyPinOe, carrierDetectOe}, 8'h05);
    @(posedge ref_clk);
    {gpioModeEn, gpioDirOut, ext} <= 12'h00F;
    tick(2);
    chk({3'h0, termReadyPinOut, ringIndicatorOe, setReadyOe, termReadyPinOe, carrierDetectOe}, 8'h1D);
  endtask
  task automatic t_rx;
    host.sendByte(8'hA5, 1'h1);
    tick(1);
    chk(mainRxData, 8'hA5);
    chkb(clearToSendPinN, 1'h1);
    host.sendByte(8'h5C, 1'h1);
    tick(1);
    chkb(mainRxOverrun, 1'h1);
    chk(mainRxData, 8'hA5);
    take();
    chkb(mainRxValid, 1'h0);
    chkb(clearToSendPinN, 1'h0);
    host.sendByte(8'h0F, 1'h0);
    tick(1);
    chkb(mainRxFrameErr, 1'h1);
    chkb(mainRxValid, 1'h0);
    take();
  endtask
  task automatic t_tx;
    int n;
    int c;
    @(posedge ref_clk);
    flowCtrlEn <= 1'h1;
    host.holdOff <= 1'h1;
    tick(6);
    @(posedge ref_clk);
    mainTxData <= 8'h3C;
    mainTxValid <= 1'h1;
    tick(4 * BIT);
    chkb(mainTxPin, 1'h1);
    chkb(mainTxReady, 1'h0);
    @(posedge ref_clk);
    c = host.rxCount;
    host.holdOff <= 1'h0;
    for (n = 0; n < 50 && mainTxReady !== 1'h1; n++) @(posedge ref_clk);
    @(posedge ref_clk);
    mainTxValid <= 1'h0;
    for (n = 0; n < 200 && host.rxCount == c; n++) @(posedge ref_clk);
    chk(host.rxByte, 8'h3C);
    // without flow control a deasserted request-to-send must not pause the sender
    @(posedge ref_clk);
    c = host.rxCount;
    flowCtrlEn <= 1'h0;
    host.holdOff <= 1'h1;
    mainTxData <= 8'hC3;
    mainTxValid <= 1'h1;
    for (n = 0; n < 50 && mainTxReady !== 1'h1; n++) @(posedge ref_clk);
    @(posedge ref_clk);
    mainTxValid <= 1'h0;
    for (n = 0; n < 200 && host.rxCount == c; n++) @(posedge ref_clk);
    chk(host.rxByte, 8'hC3);
  endtask
  task automatic t_aux;
    int n;
    @(posedge ref_clk);
    auxTxData <= 8'h5A;
    auxTxValid <= 1'h1;
    for (n = 0; n < 50 && auxTxReady !== 1'h1; n++) @(posedge ref_clk);
    @(posedge ref_clk);
    auxTxValid <= 1'h0;
    for (n = 0; n < 200 && auxRxValid !== 1'h1; n++) @(negedge ref_clk);
    chk(auxRxData, 8'h5A);
    @(posedge ref_clk);
    {spiSelect, spiMosi} <= 2'h2;
    tick(4);
    chkb(auxTxMosiPin, 1'h0);
    @(posedge ref_clk);
    spiMosi <= 1'h1;
    tick(5);
    chkb(spiMiso, 1'h1);
    chkb(auxTxReady, 1'h0);
  endtask
  initial begin
    {rstn, carrierPresent, moduleReady, incomingCall, flowCtrlEn, mainTxValid} = '0;
    {mainRxTaken, auxTxValid, spiSelect, spiMosi, mainTxData, auxTxData} = '0;
    {gpioModeEn, gpioOutVal, gpioDirOut, ext} = 16'h000F;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'h1;
    tick(2);
    t_modem();
    t_dtr();
    t_gpio();
    t_rx();
    t_tx();
    t_aux();
    end_sim();
  end
  // whole run is under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    $display("unexpected at %0t: run hung", $time);
    end_sim();
  end
endmodule // testbench
bind msp_serial_ports msp_serial_ports_asserts u_chk (.*);
